// *** rtl/spi_mem_pkg.sv ***
// Constants shared by the serial memory target, its controller and the bench.
// Assumes both ends run on the same 250 MHz system clock rate.
package spi_mem_pkg;

  localparam int          ADDR_W          = 15;
  localparam int          MEM_DEPTH       = 32768;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  localparam logic [7:0]  OP_SET_LATCH    = 8'h06;
  localparam logic [7:0]  OP_CLR_LATCH    = 8'h04;
  localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
  localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0]  OP_MEM_READ     = 8'h03;
  localparam logic [7:0]  OP_MEM_WRITE    = 8'h02;

  localparam int          ST_PPEN_BIT     = 7;
  localparam int          ST_BP_HI_BIT    = 3;
  localparam int          ST_BP_LO_BIT    = 2;
  localparam int          ST_WEL_BIT      = 1;
  localparam int          ADDR_HI_MSB     = 6;

  localparam logic [1:0]  BP_NONE         = 2'h0;
  localparam logic [1:0]  BP_QUARTER      = 2'h1;
  localparam logic [1:0]  BP_HALF         = 2'h2;
  localparam logic [1:0]  BP_ALL          = 2'h3;
  localparam logic [14:0] PROT_QUARTER    = 15'h6000;
  localparam logic [14:0] PROT_HALF       = 15'h4000;
  localparam logic [14:0] ADDR_STEP       = 15'h0001;

  // Pin synchroniser reset order: cs_n, sck, si, wp_n, hold_n
  localparam logic [4:0]  DEV_PIN_RESET   = 5'h13;
  localparam logic [0:0]  HOST_PIN_RESET  = 1'h1;

  localparam logic [3:0]  REG_TX          = 4'h0;
  localparam logic [3:0]  REG_CTRL        = 4'h4;
  localparam logic [3:0]  REG_STATUS      = 4'h8;
  localparam logic [3:0]  REG_RX          = 4'hC;
  localparam int          CTRL_SELECT     = 0;
  localparam int          CTRL_MODE3      = 1;
  localparam int          CTRL_PAUSE      = 2;
  localparam int          CTRL_PROTECT    = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          SCK_PERIOD_NS   = 64;
  localparam int          SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  function automatic logic addr_blocked(input logic [1:0] bp, input logic [14:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      BP_NONE:    hit = 1'b0;
      BP_QUARTER: hit = (addr >= PROT_QUARTER);
      BP_HALF:    hit = (addr >= PROT_HALF);
      BP_ALL:     hit = 1'b1;
    endcase
    return hit;
  endfunction : addr_blocked

endpackage : spi_mem_pkg

// *** rtl/spi_mem_if.sv ***
// Four-wire serial link plus write-protect and pause pins between controller and memory.
// Assumes the bench or board joins the two modports; data output idles high when undriven.
`timescale 1ns/1ps
`default_nettype none
interface spi_mem_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  logic wp_n;
  logic hold_n;

  // Resolved level of the shared data output wire
  assign so_line = so_oe ? so : 1'b1;

  modport device (input cs_n, input sck, input si, input wp_n, input hold_n,
                  output so, output so_oe);
  modport host   (output cs_n, output sck, output si, output wp_n, output hold_n,
                  input so_line);
endinterface : spi_mem_if
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a group of pins arriving from outside the clock domain.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             CLOCK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic [WIDTH-1:0] PINS_IN,
  output logic      [WIDTH-1:0] PINS_OUT
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      stage1_reg <= RESET_VALUE;
      PINS_OUT   <= RESET_VALUE;
    end
    else
    begin
      stage1_reg <= PINS_IN;
      PINS_OUT   <= stage1_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** rtl/spi_mem_device.sv ***
// Serial memory target: command decode, protect status, write latch and 32K x 8 array.
// Assumes link pins are asynchronous to CLOCK_IN and toggle well below its rate.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module spi_mem_device (
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_N_IN,
  spi_mem_if.device       LINK,
  output logic      [7:0] PROTECT_STATUS_OUT,
  output logic            MODE3_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b011,
    ST_WDATA  = 3'b010,
    ST_RDATA  = 3'b110,
    ST_SWRITE = 3'b111,
    ST_DONE   = 3'b101
  } dev_state_e;

  typedef struct packed {
    dev_state_e  state;
    logic        mode3;
    logic        cs_prev;
    logic        sck_prev;
    logic [2:0]  in_cnt;
    logic [2:0]  out_cnt;
    logic [7:0]  in_shift;
    logic        addr_hi_done;
    logic        is_read;
    logic        is_write;
    logic        is_status;
    logic [14:0] addr;
    logic [7:0]  out_shift;
    logic        so_bit;
    logic        so_en;
    logic        write_enable_latch;
    logic        ppen;
    logic [1:0]  bp;
    logic        wp_locked;
  } dev_s;

  localparam dev_s DEV_RESET = '{
    state: ST_IDLE, mode3: 1'b0, cs_prev: 1'b1, sck_prev: 1'b0, in_cnt: 3'h0,
    out_cnt: 3'h0, in_shift: 8'h00, addr_hi_done: 1'b0, is_read: 1'b0,
    is_write: 1'b0, is_status: 1'b0, addr: 15'h0000, out_shift: 8'h00,
    so_bit: 1'b0, so_en: 1'b0, write_enable_latch: 1'b0, ppen: 1'b0, bp: 2'h0, wp_locked: 1'b0};

  dev_s        r_reg;
  dev_s        r_next;
  logic [7:0]  mem [spi_mem_pkg::MEM_DEPTH];
  logic        mem_we;
  logic [14:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [4:0]  pins_s;
  logic        cs_s;
  logic        sck_s;
  logic        si_s;
  logic        wp_s;
  logic        hold_s;
  logic [7:0]  status;

  pin_sync #(
    .WIDTH       (5),
    .RESET_VALUE (spi_mem_pkg::DEV_PIN_RESET)
  ) u_sync (
    .CLOCK_IN (CLOCK_IN),
    .RST_N_IN (RST_N_IN),
    .PINS_IN  ({LINK.cs_n, LINK.sck, LINK.si, LINK.wp_n, LINK.hold_n}),
    .PINS_OUT (pins_s)
  );

  assign {cs_s, sck_s, si_s, wp_s, hold_s} = pins_s;

  always_comb
  begin
    status                           = 8'h00;
    status[spi_mem_pkg::ST_PPEN_BIT] = r_reg.ppen;
    status[spi_mem_pkg::ST_BP_HI_BIT] = r_reg.bp[1];
    status[spi_mem_pkg::ST_BP_LO_BIT] = r_reg.bp[0];
    status[spi_mem_pkg::ST_WEL_BIT]  = r_reg.write_enable_latch;
  end

  always_comb
  begin
    logic       active;
    logic       rise;
    logic       fall;
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    active   = ~cs_s & hold_s;
    rise     = active & sck_s & ~r_reg.sck_prev;
    fall     = active & ~sck_s & r_reg.sck_prev;
    in_byte  = {r_reg.in_shift[6:0], si_s};
    out_byte = r_reg.is_status ? status : mem[r_reg.addr];
    r_next   = r_reg;
    mem_we   = 1'b0;
    mem_wa   = r_reg.addr;
    mem_wd   = in_byte;
    r_next.cs_prev  = cs_s;
    r_next.sck_prev = sck_s;
    if (r_reg.cs_prev && !cs_s)
    begin
      r_next.state     = ST_OPCODE;
      r_next.mode3     = sck_s;
      r_next.wp_locked = ~wp_s;
      r_next.in_cnt    = 3'h0;
      r_next.out_cnt   = 3'h0;
      r_next.is_read   = 1'b0;
      r_next.is_write  = 1'b0;
      r_next.is_status = 1'b0;
      r_next.so_en     = 1'b0;
    end
    else if (!r_reg.cs_prev && cs_s)
    begin
      if (r_reg.is_write)
        r_next.write_enable_latch = 1'b0;
      r_next.state    = ST_IDLE;
      r_next.so_en    = 1'b0;
      r_next.is_write = 1'b0;
    end
    else if (rise && r_reg.state != ST_IDLE && r_reg.state != ST_DONE)
    begin
      r_next.in_shift = in_byte;
      r_next.in_cnt   = r_reg.in_cnt + 3'h1;
      if (r_reg.in_cnt == spi_mem_pkg::BIT_LAST)
      begin
        unique case (r_reg.state)
          ST_OPCODE:
          begin
            r_next.state = ST_DONE;
            unique case (in_byte)
              spi_mem_pkg::OP_SET_LATCH: r_next.write_enable_latch = 1'b1;
              spi_mem_pkg::OP_CLR_LATCH: r_next.write_enable_latch = 1'b0;
              spi_mem_pkg::OP_STATUS_READ:
              begin
                r_next.state     = ST_RDATA;
                r_next.is_status = 1'b1;
              end
              spi_mem_pkg::OP_STATUS_WRITE:
              begin
                r_next.state    = ST_SWRITE;
                r_next.is_write = 1'b1;
              end
              spi_mem_pkg::OP_MEM_READ:
              begin
                r_next.state        = ST_ADDR;
                r_next.is_read      = 1'b1;
                r_next.addr_hi_done = 1'b0;
              end
              spi_mem_pkg::OP_MEM_WRITE:
              begin
                r_next.state        = ST_ADDR;
                r_next.is_write     = 1'b1;
                r_next.addr_hi_done = 1'b0;
              end
              default: r_next.state = ST_DONE;
            endcase
          end
          ST_ADDR:
          begin
            if (!r_reg.addr_hi_done)
            begin
              r_next.addr[14:8]   = in_byte[spi_mem_pkg::ADDR_HI_MSB:0];
              r_next.addr_hi_done = 1'b1;
            end
            else
            begin
              r_next.addr[7:0] = in_byte;
              r_next.state     = r_reg.is_read ? ST_RDATA : ST_WDATA;
            end
          end
          ST_WDATA:
          begin
            mem_we      = r_reg.write_enable_latch & ~spi_mem_pkg::addr_blocked(r_reg.bp, r_reg.addr);
            r_next.addr = r_reg.addr + spi_mem_pkg::ADDR_STEP;
          end
          ST_SWRITE:
          begin
            if (r_reg.write_enable_latch && !(r_reg.ppen && r_reg.wp_locked))
            begin
              r_next.ppen = in_byte[spi_mem_pkg::ST_PPEN_BIT];
              r_next.bp   = {in_byte[spi_mem_pkg::ST_BP_HI_BIT],
                             in_byte[spi_mem_pkg::ST_BP_LO_BIT]};
            end
            r_next.state = ST_DONE;
          end
          default: r_next.state = r_reg.state;
        endcase
      end
    end
    else if (fall && r_reg.state == ST_RDATA)
    begin
      r_next.so_en   = 1'b1;
      r_next.out_cnt = r_reg.out_cnt + 3'h1;
      if (r_reg.out_cnt == 3'h0)
      begin
        r_next.so_bit    = out_byte[7];
        r_next.out_shift = {out_byte[6:0], 1'b0};
        if (!r_reg.is_status)
          r_next.addr = r_reg.addr + spi_mem_pkg::ADDR_STEP;
      end
      else
      begin
        r_next.so_bit    = r_reg.out_shift[7];
        r_next.out_shift = {r_reg.out_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      r_reg <= DEV_RESET;
    else
      r_reg <= r_next;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign LINK.so             = r_reg.so_bit;
  assign LINK.so_oe          = r_reg.so_en & ~cs_s & hold_s;
  assign PROTECT_STATUS_OUT  = status;
  assign MODE3_OUT           = r_reg.mode3;
endmodule : spi_mem_device
`default_nettype wire

// *** rtl/spi_mem_host.sv ***
// Serial memory controller: software-driven byte exchanger with select, pause and protect pins.
// Assumes software frames each command by hand through the register port.
`timescale 1ns/1ps
`default_nettype none
module spi_mem_host #(
  parameter int HALF_CYCLES = spi_mem_pkg::SCK_HALF_CYCLES
) (
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_N_IN,
  spi_mem_if.host         LINK,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW  = 2'b01,
    H_HIGH = 2'b11
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [7:0]  cnt;
    logic [2:0]  bit_cnt;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [3:0]  ctrl;
    logic        hold_pin;
    logic        sck;
    logic [7:0]  rdata;
  } host_s;

  localparam host_s HOST_RESET = '{
    state: H_IDLE, cnt: 8'h00, bit_cnt: 3'h0, tx: 8'h00, rx: 8'h00,
    ctrl: spi_mem_pkg::CTRL_RESET, hold_pin: 1'b0, sck: 1'b0, rdata: 8'h00};
  localparam logic [7:0] CNT_LAST = 8'(HALF_CYCLES - 1);

  host_s r_reg;
  host_s r_next;
  logic  so_s;

  pin_sync #(
    .WIDTH       (1),
    .RESET_VALUE (spi_mem_pkg::HOST_PIN_RESET)
  ) u_sync (
    .CLOCK_IN (CLOCK_IN),
    .RST_N_IN (RST_N_IN),
    .PINS_IN  (LINK.so_line),
    .PINS_OUT (so_s)
  );

  always_comb
  begin
    r_next       = r_reg;
    r_next.rdata = 8'h00;
    if (RD_IN)
    begin
      unique case (ADDR_IN)
        spi_mem_pkg::REG_CTRL:   r_next.rdata = {4'h0, r_reg.ctrl};
        spi_mem_pkg::REG_STATUS: r_next.rdata = {7'h00, r_reg.state != H_IDLE};
        spi_mem_pkg::REG_RX:     r_next.rdata = r_reg.rx;
        default:                 r_next.rdata = 8'h00;
      endcase
    end
    if (WR_IN && ADDR_IN == spi_mem_pkg::REG_CTRL)
      r_next.ctrl = WDATA_IN[3:0];
    unique case (r_reg.state)
      H_IDLE:
      begin
        r_next.sck = r_reg.ctrl[spi_mem_pkg::CTRL_MODE3];
        if (WR_IN && ADDR_IN == spi_mem_pkg::REG_TX && r_reg.ctrl[spi_mem_pkg::CTRL_SELECT])
        begin
          r_next.tx      = WDATA_IN;
          r_next.state   = H_LOW;
          r_next.sck     = 1'b0;
          r_next.cnt     = 8'h00;
          r_next.bit_cnt = 3'h0;
        end
      end
      H_LOW:
      begin
        if (!r_reg.hold_pin)
        begin
          r_next.cnt = r_reg.cnt + 8'h01;
          if (r_reg.cnt == CNT_LAST)
          begin
            r_next.state = H_HIGH;
            r_next.sck   = 1'b1;
            r_next.cnt   = 8'h00;
          end
        end
      end
      H_HIGH:
      begin
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt == CNT_LAST)
        begin
          r_next.cnt = 8'h00;
          r_next.rx  = {r_reg.rx[6:0], so_s};
          if (r_reg.bit_cnt == spi_mem_pkg::BIT_LAST)
          begin
            r_next.state = H_IDLE;
            r_next.sck   = r_reg.ctrl[spi_mem_pkg::CTRL_MODE3];
          end
          else
          begin
            r_next.state   = H_LOW;
            r_next.sck     = 1'b0;
            r_next.tx      = {r_reg.tx[6:0], 1'b0};
            r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
          end
        end
      end
    endcase
    if (!r_reg.sck && !r_next.sck)
      r_next.hold_pin = r_reg.ctrl[spi_mem_pkg::CTRL_PAUSE];
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      r_reg <= HOST_RESET;
    else
      r_reg <= r_next;
  end

  assign LINK.cs_n   = ~r_reg.ctrl[spi_mem_pkg::CTRL_SELECT];
  assign LINK.sck    = r_reg.sck;
  assign LINK.si     = r_reg.tx[7];
  assign LINK.wp_n   = ~r_reg.ctrl[spi_mem_pkg::CTRL_PROTECT];
  assign LINK.hold_n = ~r_reg.hold_pin;
  assign RDATA_OUT   = r_reg.rdata;
endmodule : spi_mem_host
`default_nettype wire

// *** testbench/spi_mem_chk.sv ***
// Checker on the link wires between the memory controller and the memory.
// Assumes the bench instantiates it beside the link interface, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module spi_mem_chk (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic CS_N_IN,
  input wire logic SCK_IN,
  input wire logic SI_IN,
  input wire logic SO_IN,
  input wire logic SO_OE_IN,
  input wire logic HOLD_N_IN
);
  default clocking dc @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  a_oe_deselect: assert property (CS_N_IN [*5] |-> !SO_OE_IN)
    else $error("data output driven while deselected");
  a_oe_paused: assert property (!HOLD_N_IN [*5] |-> !SO_OE_IN)
    else $error("data output driven while paused");
  a_oe_release: assert property ($rose(CS_N_IN) |-> ##[1:4] !SO_OE_IN)
    else $error("data output not released after select rise");
  a_so_on_fall: assert property (SO_OE_IN && $past(SO_OE_IN) && (SO_IN != $past(SO_IN)) |-> !SCK_IN)
    else $error("data output changed while serial clock high");
  a_oe_rise_low: assert property ($rose(SO_OE_IN) |-> !SCK_IN && !CS_N_IN)
    else $error("data output enabled outside a selected low clock phase");
  a_mode_stable: assert property ($fell(CS_N_IN) |-> $stable(SCK_IN))
    else $error("serial clock moved at select fall");
  a_si_settled: assert property ($rose(SCK_IN) |-> $stable(SI_IN) ##1 $stable(SI_IN))
    else $error("data input moved around rising clock");
  a_pause_low: assert property ($changed(HOLD_N_IN) |-> !SCK_IN)
    else $error("pause pin moved while serial clock high");

  c_read_data: cover property ($rose(SO_OE_IN));
  c_mode3_sel: cover property ($fell(CS_N_IN) && SCK_IN);
  c_paused: cover property ($fell(HOLD_N_IN));
endmodule : spi_mem_chk
`default_nettype wire

// *** testbench/spi_serial_memory_protect_bench.sv ***
// Bench for the serial memory pair: controller registers drive the memory across the link.
// Assumes a 250 MHz clock; a model of memory and protect state predicts each result except reads of bytes never written.
`timescale 1ns/1ps
`default_nettype none
module spi_serial_memory_protect_bench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] status;
  logic       mode3_seen;
  int         fail_count = 0;
  int         checked = 0;
  logic [7:0] mem[int];
  logic       write_enable_latch = 1'b0, ppen = 1'b0, prot = 1'b0, mode3 = 1'b0;
  logic [1:0] bp = 2'h0;
  logic [7:0] rxq[$];
  logic [7:0] b;
  logic [15:0] starts[4] = '{16'hFFFE, 16'hDFFE, 16'h7FFE, 16'h5FFE};

  spi_mem_if link();
  spi_mem_host u_spi_mem_host (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK(link), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata));
  spi_mem_device u_spi_mem_device (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK(link),
    .PROTECT_STATUS_OUT(status), .MODE3_OUT(mode3_seen));
  spi_mem_chk u_spi_mem_chk (.CLOCK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(link.cs_n),
    .SCK_IN(link.sck), .SI_IN(link.si), .SO_IN(link.so), .SO_OE_IN(link.so_oe),
    .HOLD_N_IN(link.hold_n));

  always #(spi_mem_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  function automatic logic [7:0] ctl(input logic sel, input logic ps);
    return {4'h0, prot, ps, mode3, sel};
  endfunction : ctl

  function automatic logic [7:0] st();
    return {ppen, 3'h0, bp, write_enable_latch, 1'b0};
  endfunction : st

  function automatic logic blk(input logic [14:0] x);
    return (bp == 2'h3) || (bp == 2'h2 && x >= 15'h4000) || (bp == 2'h1 && x >= 15'h6000);
  endfunction : blk

  // One select period: bytes out, received bytes into rxq, optional pause before a byte
  task automatic frame(input logic [7:0] q[$], input int pause_at);
    rxq = {};
    reg_wr(spi_mem_pkg::REG_CTRL, ctl(1'b0, 1'b0));
    reg_wr(spi_mem_pkg::REG_CTRL, ctl(1'b1, 1'b0));
    repeat (4) @(posedge clk);
    foreach (q[i])
    begin
      if (i == pause_at)
      begin
        reg_wr(spi_mem_pkg::REG_CTRL, ctl(1'b1, 1'b1));
        repeat (24) @(posedge clk);
        reg_wr(spi_mem_pkg::REG_CTRL, ctl(1'b1, 1'b0));
        repeat (4) @(posedge clk);
      end
      reg_wr(spi_mem_pkg::REG_TX, q[i]);
      b = 8'h01;
      for (int n = 0; n < 200 && b[0]; n++)
        reg_rd(spi_mem_pkg::REG_STATUS, b);
      check({7'h0, b[0]}, 8'h00);
      reg_rd(spi_mem_pkg::REG_RX, b);
      rxq.push_back(b);
    end
    reg_wr(spi_mem_pkg::REG_CTRL, ctl(1'b0, 1'b0));
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic stat_chk();
    frame({spi_mem_pkg::OP_STATUS_READ, 8'h00, 8'h00}, -1);
    check(rxq[1], st());
    check(rxq[2], st());
    check(status, st());
    check({7'h0, mode3_seen}, {7'h0, mode3});
  endtask : stat_chk

  task automatic set_latch();
    frame({spi_mem_pkg::OP_SET_LATCH, spi_mem_pkg::OP_CLR_LATCH}, -1);
    write_enable_latch = 1'b1;
  endtask : set_latch

  task automatic swr(input logic [7:0] v);
    frame({spi_mem_pkg::OP_STATUS_WRITE, v}, -1);
    if (write_enable_latch && !(ppen && prot))
    begin
      ppen = v[7];
      bp = v[3:2];
    end
    write_enable_latch = 1'b0;
    stat_chk();
  endtask : swr

  task automatic mwr(input logic [15:0] a, input int pause_at);
    logic [7:0]  q[$];
    logic [14:0] x;
    q = {spi_mem_pkg::OP_MEM_WRITE, a[15:8], a[7:0]};
    for (int k = 0; k < 4; k++)
    begin
      x = a[14:0] + k[14:0];
      b = 8'($urandom);
      q.push_back(b);
      if (write_enable_latch && !blk(x))
        mem[x] = b;
    end
    frame(q, pause_at);
    write_enable_latch = 1'b0;
  endtask : mwr

  task automatic mrd(input logic [15:0] a);
    logic [14:0] x;
    frame({spi_mem_pkg::OP_MEM_READ, a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h00}, -1);
    for (int k = 0; k < 4; k++)
    begin
      x = a[14:0] + k[14:0];
      if (mem.exists(x))
        check(rxq[3 + k], mem[x]);
    end
  endtask : mrd

  initial
  begin
    int seed;
    seed = $urandom(32'hF12EA392);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_wr(4'h2, 8'hFF);
    reg_rd(4'h2, b);
    check(b, 8'h00);
    stat_chk();
    swr(8'hFF);
    set_latch();
    stat_chk();
    frame({spi_mem_pkg::OP_CLR_LATCH}, -1);
    write_enable_latch = 1'b0;
    stat_chk();
    set_latch();
    swr(8'hFF);
    prot = 1'b1;
    set_latch();
    swr(8'h00);
    reg_rd(spi_mem_pkg::REG_CTRL, b);
    check(b, ctl(1'b0, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      mode3 = i[0];
      prot = 1'b0;
      set_latch();
      swr({i[0], 3'h0, i[1:0], 2'h0});
      prot = 1'b1;
      set_latch();
      mwr(starts[i], mode3 ? -1 : 4);
      mwr(starts[i], -1);
      mrd(starts[i] ^ 16'h8000);
    end
    wrap_up();
  end

  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : spi_serial_memory_protect_bench
`default_nettype wire
